// ==== logic/dlhs_pkg.sv ====
// Shared constants and types of the debug link handshake and timing-reference logic.
package dlhs_pkg;
    // -------------------------------------------------------------------------
    // Serial clock derivation
    // -------------------------------------------------------------------------
    localparam int DLHS_SYS_CLK_MHZ = 100;
    localparam int DLHS_SER_DIV = 8;
    localparam int DLHS_SER_DIV_W = 3;

    // -------------------------------------------------------------------------
    // Serial cycle counts
    // -------------------------------------------------------------------------
    localparam int DLHS_CNT_W = 9;
    localparam logic [8:0] DLHS_LONG_LOW = 9'h080;
    localparam logic [8:0] DLHS_REF_LOW = 9'h080;
    localparam logic [8:0] DLHS_SETTLE = 9'h010;
    localparam logic [8:0] DLHS_ACK_LOW = 9'h010;
    localparam logic [8:0] DLHS_ACK_MIN_GAP = 9'h020;
    localparam logic [8:0] DLHS_SHORT_LOW = 9'h004;
    localparam logic [8:0] DLHS_HOST_LONG = 9'h084;
    localparam logic [8:0] DLHS_CNT_MAX = 9'h1FF;

    // -------------------------------------------------------------------------
    // Command classes, as delivered by the decoder of the debug engine
    // -------------------------------------------------------------------------
    typedef enum logic [2:0] {
        DLHS_CMD_READ = 3'h0,
        DLHS_CMD_WRITE = 3'h1,
        DLHS_CMD_HALT = 3'h2,
        DLHS_CMD_RESUME = 3'h3,
        DLHS_CMD_RUN_UNTIL = 3'h4,
        DLHS_CMD_STEP = 3'h5,
        DLHS_CMD_HS_ON = 3'h6,
        DLHS_CMD_HS_OFF = 3'h7
    } dlhs_cmd_t;

    // -------------------------------------------------------------------------
    // Abort kinds requested by the host user side
    // -------------------------------------------------------------------------
    typedef enum logic [1:0] {
        DLHS_ABORT_NONE = 2'h0,
        DLHS_ABORT_LONG = 2'h1,
        DLHS_ABORT_SHORT = 2'h2
    } dlhs_abort_t;
endpackage

// ==== logic/dlhs_link_if.sv ====
// Single-wire debug pin carrier joining the device end and the host end.
`timescale 1ns/10ps
interface dlhs_link_if;
    logic dev_pin_o;
    logic dev_pin_oe;
    logic host_pin_o;
    logic host_pin_oe;
    logic pin_i;

    // -------------------------------------------------------------------------
    // Wire level: a driver wins, otherwise the pull-up holds the line high
    // -------------------------------------------------------------------------
    assign pin_i = dev_pin_oe ? dev_pin_o : (host_pin_oe ? host_pin_o : 1'b1);

    modport device (output dev_pin_o, output dev_pin_oe, input pin_i);
    modport host (output host_pin_o, output host_pin_oe, input pin_i);
endinterface

// ==== logic/dlhs_ser_tick.sv ====
// Serial clock enable: divides the system clock by a fixed ratio.
`timescale 1ns/10ps
module dlhs_ser_tick #(
    parameter int DIV = dlhs_pkg::DLHS_SER_DIV
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Enable
    output logic tick
);
    import dlhs_pkg::*;

    // The count register is eight bits wide, so larger ratios cannot be served.
    if (DIV < 2 || DIV > 256) begin : g_div_check
        $error("dlhs_ser_tick: DIV out of range");
    end

    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } dlhs_tick_st_t;

    dlhs_tick_st_t st_q;
    dlhs_tick_st_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.tick = 1'b0;
        if (st_q.cnt == 8'(DIV - 1)) begin
            st_d.cnt = 8'h00;
            st_d.tick = 1'b1;
        end else begin
            st_d.cnt = st_q.cnt + 8'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign tick = st_q.tick;
endmodule

// ==== logic/dlhs_device.sv ====
// Device end: acknowledge pulses, abort detection and timing-reference response.
`timescale 1ns/10ps

// Contract
// - Host aborts with 128-cycle low plus speedup.
// - Long low runs reference, cancels command.
// - Started memory access completes, acknowledge dropped.
// - Resume, step, run-until continue; acknowledge dropped.
// - Short low cancels but gives no reference.
// - Short abort at least 4 cycles.
// - Next falling edge after abort starts command.
// - Handshake on acknowledges itself; off disables.
// - Handshake disabled after reset.
// - Read acknowledges when bus data ready.
// - Write acknowledges after data and bus done.
// - Host probes support with handshake on.
// - Halt acknowledges on entering background mode.
// - Resume acknowledges on leaving background mode.
// - Run-until acknowledges on next background entry.
// - Step acknowledges on return after one instruction.
// - Host requests reference with long low.
// - Device waits high, 16, drives 128 low.
// - Host measures reference low to set speed.
// - Reference request soft-resets the serial interface.
// - Known-rate host may use slightly-over-128 abort.
// - Acknowledge is 16 low then speedup.
// - Acknowledge no earlier than 32 after command.
module dlhs_device (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Debug pin
    dlhs_link_if.device link,
    // Command from the serial decoder, pulsed at the sixteenth tick of the last bit
    input wire logic cmd_done,
    input wire dlhs_pkg::dlhs_cmd_t cmd_class,
    // Completion events from the debug engine and CPU
    input wire logic bus_done,
    input wire logic cpu_enter_bg,
    input wire logic cpu_leave_bg,
    // Serial engine status: a receive or transmit bit is in flight
    input wire logic ser_busy,
    // Status towards the debug engine
    output logic hs_enabled,
    output logic ack_pending,
    output logic soft_reset,
    output logic abort_seen,
    output logic new_cmd_edge
);
    import dlhs_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_REQ_LOW = 3'h1,
        ST_WAIT_HIGH = 3'h2,
        ST_SETTLE = 3'h3,
        ST_REF_LOW = 3'h4,
        ST_REF_UP = 3'h5,
        ST_ACK_LOW = 3'h6,
        ST_ACK_UP = 3'h7
    } dlhs_dev_state_t;

    typedef struct packed {
        dlhs_dev_state_t st;
        logic sync1;
        logic sync2;
        logic pin_prev;
        logic [8:0] cnt;
        logic [8:0] gap;
        logic hs_en;
        logic wait_ev;
        dlhs_cmd_t pend;
        logic ready;
        logic pin_o;
        logic pin_oe;
        logic soft_rst;
        logic abort;
        logic new_edge;
        logic ack_pend;
    } dlhs_dev_st_t;

    dlhs_dev_st_t q;
    dlhs_dev_st_t d;
    logic tick;
    logic fall;
    logic event_hit;

    dlhs_ser_tick #(.DIV(DLHS_SER_DIV)) u_tick (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .tick(tick)
    );

    // -------------------------------------------------------------------------
    // Which completion event finishes the pending command
    // -------------------------------------------------------------------------
    function automatic logic ack_event(input dlhs_cmd_t c, input logic bd,
                                       input logic enter, input logic leave);
        logic r;
        r = 1'b0;
        unique case (c)
            DLHS_CMD_READ, DLHS_CMD_WRITE: r = bd;
            DLHS_CMD_HALT, DLHS_CMD_RUN_UNTIL: r = enter;
            DLHS_CMD_STEP: r = enter;
            DLHS_CMD_RESUME: r = leave;
            DLHS_CMD_HS_ON: r = 1'b1;
            DLHS_CMD_HS_OFF: r = 1'b0;
        endcase
        return r;
    endfunction

    // Only the second synchroniser stage and later are examined.
    assign fall = q.pin_prev & ~q.sync2;
    assign event_hit = ack_event(q.pend, bus_done, cpu_enter_bg, cpu_leave_bg);

    always_comb begin
        d = q;
        d.soft_rst = 1'b0;
        d.abort = 1'b0;
        d.new_edge = 1'b0;
        d.sync1 = link.pin_i;
        d.sync2 = q.sync1;
        if (tick) begin
            d.pin_prev = q.sync2;
        end
        // Completion events arrive on the system clock; they are latched so
        // that no event is missed between serial ticks.
        if (q.wait_ev && event_hit) begin
            d.wait_ev = 1'b0;
            d.ready = 1'b1;
        end
        if (cmd_done) begin
            d.gap = '0;
            if (cmd_class == DLHS_CMD_HS_ON) begin
                d.hs_en = 1'b1;
            end else if (cmd_class == DLHS_CMD_HS_OFF) begin
                d.hs_en = 1'b0;
            end
            // The enable command answers itself even when it arrives disabled.
            d.wait_ev = (q.hs_en || cmd_class == DLHS_CMD_HS_ON)
                && cmd_class != DLHS_CMD_HS_OFF;
            d.ready = 1'b0;
            d.pend = cmd_class;
        end else if (tick && q.gap != DLHS_CNT_MAX) begin
            d.gap = q.gap + 9'h001;
        end
        if (tick) begin
            unique case (q.st)
                ST_IDLE: begin
                    if (fall) begin
                        d.cnt = 9'h001;
                        d.st = ST_REQ_LOW;
                        d.new_edge = 1'b1;
                        if (q.wait_ev || q.ready) begin
                            // Work already started is left to finish; only the
                            // acknowledge is withdrawn.
                            d.wait_ev = 1'b0;
                            d.ready = 1'b0;
                            d.abort = 1'b1;
                        end
                    end else if (q.ready && q.gap >= DLHS_ACK_MIN_GAP && !ser_busy) begin
                        d.ready = 1'b0;
                        d.cnt = '0;
                        d.pin_o = 1'b0;
                        d.pin_oe = 1'b1;
                        d.st = ST_ACK_LOW;
                    end
                end
                ST_REQ_LOW: begin
                    if (q.sync2) begin
                        d.st = ST_IDLE;
                    end else if (q.cnt == DLHS_LONG_LOW) begin
                        d.soft_rst = 1'b1;
                        d.abort = 1'b1;
                        d.wait_ev = 1'b0;
                        d.ready = 1'b0;
                        d.st = ST_WAIT_HIGH;
                    end else if (q.cnt != DLHS_CNT_MAX) begin
                        d.cnt = q.cnt + 9'h001;
                    end
                end
                ST_WAIT_HIGH: begin
                    if (q.sync2) begin
                        d.cnt = '0;
                        d.st = ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    d.cnt = q.cnt + 9'h001;
                    if (q.cnt == DLHS_SETTLE - 9'h001) begin
                        d.cnt = '0;
                        d.pin_o = 1'b0;
                        d.pin_oe = 1'b1;
                        d.st = ST_REF_LOW;
                    end
                end
                ST_REF_LOW: begin
                    d.cnt = q.cnt + 9'h001;
                    if (q.cnt == DLHS_REF_LOW - 9'h001) begin
                        d.pin_o = 1'b1;
                        d.st = ST_REF_UP;
                    end
                end
                ST_ACK_LOW: begin
                    d.cnt = q.cnt + 9'h001;
                    if (q.cnt == DLHS_ACK_LOW - 9'h001) begin
                        d.pin_o = 1'b1;
                        d.st = ST_ACK_UP;
                    end
                end
                ST_REF_UP, ST_ACK_UP: begin
                    d.pin_oe = 1'b0;
                    d.pin_o = 1'b0;
                    d.pin_prev = 1'b1;
                    d.st = ST_IDLE;
                end
            endcase
        end
        d.ack_pend = d.wait_ev | d.ready;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            q <= '{st: ST_IDLE, sync1: 1'b1, sync2: 1'b1, pin_prev: 1'b1,
                   cnt: '0, gap: '0, hs_en: 1'b0, wait_ev: 1'b0,
                   pend: DLHS_CMD_READ, ready: 1'b0, pin_o: 1'b0, pin_oe: 1'b0,
                   soft_rst: 1'b0, abort: 1'b0, new_edge: 1'b0, ack_pend: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign link.dev_pin_o = q.pin_o;
    assign link.dev_pin_oe = q.pin_oe;
    assign hs_enabled = q.hs_en;
    assign ack_pending = q.ack_pend;
    assign soft_reset = q.soft_rst;
    assign abort_seen = q.abort;
    assign new_cmd_edge = q.new_edge;
endmodule

// ==== logic/dlhs_host.sv ====
// Host end: sends long or short abort pulses and measures the timing reference.
`timescale 1ns/10ps
module dlhs_host (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Debug pin
    dlhs_link_if.host link,
    // User requests
    input wire logic req_valid,
    input wire dlhs_pkg::dlhs_abort_t req_kind,
    // Results
    output logic busy,
    output logic ack_seen,
    output logic ref_valid,
    output logic [15:0] ref_low_clks
);
    import dlhs_pkg::*;

    typedef enum logic [2:0] {
        HS_IDLE = 3'h0,
        HS_LOW = 3'h1,
        HS_UP = 3'h2,
        HS_LISTEN = 3'h3,
        HS_MEASURE = 3'h4
    } dlhs_host_state_t;

    typedef struct packed {
        dlhs_host_state_t st;
        logic sync1;
        logic sync2;
        logic prev;
        logic [8:0] len;
        logic [8:0] cnt;
        logic [15:0] meas;
        logic [15:0] lowc;
        logic pin_o;
        logic pin_oe;
        logic busy;
        logic ack;
        logic refv;
    } dlhs_host_st_t;

    dlhs_host_st_t q;
    dlhs_host_st_t d;
    logic tick;

    dlhs_ser_tick #(.DIV(DLHS_SER_DIV)) u_tick (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .tick(tick)
    );

    always_comb begin
        d = q;
        d.ack = 1'b0;
        d.refv = 1'b0;
        d.sync1 = link.pin_i;
        d.sync2 = q.sync1;
        d.prev = q.sync2;
        unique case (q.st)
            HS_IDLE: begin
                // A low that rises while idle is an acknowledge from the device.
                if (!q.prev && q.sync2 && !q.pin_oe) begin
                    d.ack = 1'b1;
                end
                if (req_valid && req_kind != DLHS_ABORT_NONE) begin
                    // Short aborts are kept at four cycles; the long one is kept
                    // a little over 128 since the rate is known.
                    d.len = (req_kind == DLHS_ABORT_LONG) ? DLHS_HOST_LONG
                        : DLHS_SHORT_LOW;
                    d.cnt = '0;
                    d.busy = 1'b1;
                    d.st = HS_LOW;
                end
            end
            HS_LOW: begin
                // Drive starts on a tick so that the low lasts exactly the counted ticks.
                if (tick && !q.pin_oe) begin
                    d.pin_o = 1'b0;
                    d.pin_oe = 1'b1;
                end else if (tick) begin
                    d.cnt = q.cnt + 9'h001;
                    if (q.cnt == q.len - 9'h001) begin
                        d.pin_o = 1'b1;
                        d.st = HS_UP;
                    end
                end
            end
            HS_UP: begin
                if (tick) begin
                    d.pin_oe = 1'b0;
                    d.pin_o = 1'b0;
                    if (q.len == DLHS_HOST_LONG) begin
                        d.st = HS_LISTEN;
                    end else begin
                        d.busy = 1'b0;
                        d.st = HS_IDLE;
                    end
                end
            end
            HS_LISTEN: begin
                if (q.prev && !q.sync2) begin
                    d.meas = 16'h0001;
                    d.st = HS_MEASURE;
                end
            end
            HS_MEASURE: begin
                if (q.sync2) begin
                    d.lowc = q.meas;
                    d.refv = 1'b1;
                    d.busy = 1'b0;
                    d.st = HS_IDLE;
                end else if (q.meas != 16'hFFFF) begin
                    d.meas = q.meas + 16'h0001;
                end
            end
            default: begin
                d.st = HS_IDLE;
                d.pin_oe = 1'b0;
                d.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            q <= '{st: HS_IDLE, sync1: 1'b1, sync2: 1'b1, prev: 1'b1, len: '0,
                   cnt: '0, meas: '0, lowc: '0, pin_o: 1'b0, pin_oe: 1'b0,
                   busy: 1'b0, ack: 1'b0, refv: 1'b0};
        end else begin
            q <= d;
        end
    end

    assign link.host_pin_o = q.pin_o;
    assign link.host_pin_oe = q.pin_oe;
    assign busy = q.busy;
    assign ack_seen = q.ack;
    assign ref_valid = q.refv;
    assign ref_low_clks = q.lowc;
endmodule

// ==== test/dlhs_link_chk.sv ====
// Wire-level assertions on the single-wire debug pin carrier.
`timescale 1ns/10ps
module dlhs_link_chk (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Pin carrier
    input wire logic dev_pin_o,
    input wire logic dev_pin_oe,
    input wire logic host_pin_o,
    input wire logic host_pin_oe,
    input wire logic pin_i
);
    logic dev_low;
    logic dev_high;
    logic host_low;
    logic host_high;
    logic [10:0] dev_low_q;
    logic [10:0] host_low_q;
    logic [7:0] high_q;

    assign dev_low = dev_pin_oe & ~dev_pin_o;
    assign dev_high = dev_pin_oe & dev_pin_o;
    assign host_low = host_pin_oe & ~host_pin_o;
    assign host_high = host_pin_oe & host_pin_o;

    // -------------------------------------------------------------------------
    // Run lengths of driven lows and of the idle high level
    // -------------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            dev_low_q <= 11'h000;
            host_low_q <= 11'h000;
            high_q <= 8'h00;
        end else begin
            dev_low_q <= dev_low ? dev_low_q + 11'h001 : 11'h000;
            host_low_q <= host_low ? host_low_q + 11'h001 : 11'h000;
            // Saturates so that a long idle line never wraps to a short count.
            high_q <= !pin_i ? 8'h00 : ((high_q == 8'hFF) ? high_q : high_q + 8'h01);
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    a_dev_low_len: assert property (
        $fell(dev_low) && dev_pin_oe |-> dev_low_q == 11'h080 || dev_low_q == 11'h400)
        else $error("device low pulse has wrong length");
    a_dev_speedup: assert property (
        $rose(dev_high) |-> dev_high [*8] ##1 !dev_pin_oe)
        else $error("device speedup pulse not one tick then release");
    a_dev_start_low: assert property (
        $rose(dev_pin_oe) |-> !dev_pin_o)
        else $error("device drive did not start low");
    a_dev_waits_high: assert property (
        $rose(dev_pin_oe) |-> high_q >= 8'h78)
        else $error("device drove before the line was idle long enough");
    a_no_clash: assert property (
        !(dev_pin_oe && host_pin_oe))
        else $error("both ends drive the pin");
    a_host_low_len: assert property (
        $fell(host_low) && host_pin_oe |-> host_low_q == 11'h020 || host_low_q == 11'h420)
        else $error("host low pulse has wrong length");
    a_host_release: assert property (
        $rose(host_high) |-> host_high [*8] ##1 !host_pin_oe)
        else $error("host speedup pulse not one tick then release");
    a_quiet_reset: assert property (
        $rose(resetn) |-> (!dev_pin_oe && !host_pin_oe) [*8])
        else $error("pin driven right after reset");

    c_ack: cover property ($fell(dev_low) && dev_pin_oe && dev_low_q == 11'h080);
    c_ref: cover property ($fell(dev_low) && dev_pin_oe && dev_low_q == 11'h400);
    c_short: cover property ($fell(host_low) && host_pin_oe && host_low_q == 11'h020);
endmodule

// ==== test/tb_debug_link_handshake_sync.sv ====
// Testbench joining the device end and the host end across the pin carrier.
`timescale 1ns/10ps
module tb_debug_link_handshake_sync;
    import dlhs_pkg::*;
    logic sys_clk;
    logic resetn;
    logic cmd_done;
    dlhs_cmd_t cmd_class;
    logic bus_done;
    logic cpu_enter_bg;
    logic cpu_leave_bg;
    logic ser_busy;
    logic req_valid;
    dlhs_abort_t req_kind;
    logic hs_enabled;
    logic ack_pending;
    logic soft_reset;
    logic abort_seen;
    logic new_cmd_edge;
    logic busy;
    logic ack_seen;
    logic ref_valid;
    logic [15:0] ref_low_clks;
    int fails = 0;
    int n_checks = 0;
    int acks = 0;
    int resets = 0;
    int aborts = 0;
    int edges = 0;
    int refs = 0;
    int cyc = 0;
    int t0;
    int base;
    int r0;
    int a0;
    int e0;
    int f0;
    dlhs_cmd_t cls_tab [6];
    int ev_tab [6];
    int ev_bad [6];

    dlhs_link_if link ();
    dlhs_device dlhs_device_inst (.sys_clk(sys_clk), .resetn(resetn), .link(link),
        .cmd_done(cmd_done), .cmd_class(cmd_class), .bus_done(bus_done),
        .cpu_enter_bg(cpu_enter_bg), .cpu_leave_bg(cpu_leave_bg), .ser_busy(ser_busy),
        .hs_enabled(hs_enabled), .ack_pending(ack_pending), .soft_reset(soft_reset),
        .abort_seen(abort_seen), .new_cmd_edge(new_cmd_edge));
    dlhs_host dlhs_host_inst (.sys_clk(sys_clk), .resetn(resetn), .link(link),
        .req_valid(req_valid), .req_kind(req_kind), .busy(busy), .ack_seen(ack_seen),
        .ref_valid(ref_valid), .ref_low_clks(ref_low_clks));
    dlhs_link_chk dlhs_link_chk_inst (.sys_clk(sys_clk), .resetn(resetn),
        .dev_pin_o(link.dev_pin_o), .dev_pin_oe(link.dev_pin_oe),
        .host_pin_o(link.host_pin_o), .host_pin_oe(link.host_pin_oe), .pin_i(link.pin_i));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // Pulse outputs are counted so that tests compare totals, not single cycles.
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (ack_seen === 1'b1) acks <= acks + 1;
        if (soft_reset === 1'b1) resets <= resets + 1;
        if (abort_seen === 1'b1) aborts <= aborts + 1;
        if (new_cmd_edge === 1'b1) edges <= edges + 1;
        if (ref_valid === 1'b1) refs <= refs + 1;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic send_cmd(input dlhs_cmd_t c);
        @(posedge sys_clk);
        cmd_done <= 1'b1;
        cmd_class <= c;
        t0 = cyc;
        base = acks;
        @(posedge sys_clk);
        cmd_done <= 1'b0;
    endtask

    task automatic cpu_ev(input int k);
        @(posedge sys_clk);
        base = acks;
        bus_done <= (k == 1);
        cpu_enter_bg <= (k == 2);
        cpu_leave_bg <= (k == 3);
        @(posedge sys_clk);
        bus_done <= 1'b0;
        cpu_enter_bg <= 1'b0;
        cpu_leave_bg <= 1'b0;
    endtask

    task automatic wait_ack();
        for (int i = 0; i < 2000 && acks == base; i++) @(negedge sys_clk);
    endtask

    task automatic host_req(input dlhs_abort_t k);
        @(posedge sys_clk);
        r0 = resets;
        a0 = aborts;
        e0 = edges;
        f0 = refs;
        req_valid <= 1'b1;
        req_kind <= k;
        @(posedge sys_clk);
        req_valid <= 1'b0;
        req_kind <= DLHS_ABORT_NONE;
        @(negedge sys_clk);
        for (int i = 0; i < 5000 && busy !== 1'b0; i++) @(negedge sys_clk);
        idle(50);
    endtask

    task automatic tally_and_finish();
        $display("Checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge sys_clk);
        fails++;
        tally_and_finish();
    end

    initial begin
        cls_tab = '{DLHS_CMD_READ, DLHS_CMD_WRITE, DLHS_CMD_HALT, DLHS_CMD_RESUME,
            DLHS_CMD_RUN_UNTIL, DLHS_CMD_STEP};
        ev_tab = '{1, 1, 2, 3, 2, 2};
        // An event of the wrong kind for each command; it must not finish it.
        ev_bad = '{3, 2, 1, 2, 3, 1};
        resetn = 1'b0;
        cmd_done = 1'b0;
        cmd_class = DLHS_CMD_READ;
        bus_done = 1'b0;
        cpu_enter_bg = 1'b0;
        cpu_leave_bg = 1'b0;
        ser_busy = 1'b0;
        req_valid = 1'b0;
        req_kind = DLHS_ABORT_NONE;
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        idle(4);
        check({15'h0000, hs_enabled}, 16'h0000);
        check({15'h0000, ack_pending}, 16'h0000);
        $display("Test reset done");

        send_cmd(DLHS_CMD_HS_ON);
        wait_ack();
        check(16'(acks - base), 16'h0001);
        check({15'h0000, (cyc - t0) >= 384}, 16'h0001);
        check({15'h0000, hs_enabled}, 16'h0001);
        $display("Test handshake on done");

        for (int i = 0; i < 6; i++) begin
            send_cmd(cls_tab[i]);
            cpu_ev(ev_bad[i]);
            idle(400);
            check(16'(acks - base), 16'h0000);
            cpu_ev(ev_tab[i]);
            wait_ack();
            check(16'(acks - base), 16'h0001);
        end
        $display("Test command acknowledges done");

        send_cmd(DLHS_CMD_HS_OFF);
        idle(500);
        check(16'(acks - base), 16'h0000);
        check({15'h0000, hs_enabled}, 16'h0000);
        send_cmd(DLHS_CMD_READ);
        idle(300);
        cpu_ev(1);
        idle(600);
        check(16'(acks - base), 16'h0000);
        @(posedge sys_clk);
        ser_busy <= 1'b1;
        send_cmd(DLHS_CMD_HS_ON);
        idle(500);
        check(16'(acks - base), 16'h0000);
        @(posedge sys_clk);
        ser_busy <= 1'b0;
        wait_ack();
        check(16'(acks - base), 16'h0001);
        $display("Test handshake off done");

        send_cmd(DLHS_CMD_READ);
        idle(50);
        host_req(DLHS_ABORT_LONG);
        check(16'(resets - r0), 16'h0001);
        check(16'(aborts - a0), 16'h0002);
        check(16'(refs - f0), 16'h0001);
        check({15'h0000, ack_pending}, 16'h0000);
        check({15'h0000, ref_low_clks >= 16'h03F8 && ref_low_clks <= 16'h0408}, 16'h0001);
        cpu_ev(1);
        idle(600);
        check(16'(acks - base), 16'h0000);
        $display("Test long abort done");

        send_cmd(DLHS_CMD_HALT);
        idle(50);
        host_req(DLHS_ABORT_SHORT);
        check(16'(aborts - a0), 16'h0001);
        check(16'(resets - r0), 16'h0000);
        check(16'(edges - e0), 16'h0001);
        check(16'(refs - f0), 16'h0000);
        cpu_ev(2);
        idle(600);
        check(16'(acks - base), 16'h0000);
        $display("Test short abort done");
        tally_and_finish();
    end
endmodule
